// ==== design/hub_port_ctl.v ====
// hub port selective suspend/resume and upstream port status/control logic
// assumes AXI4-Lite register access on clk_i; pins arrive asynchronous, SIE strobes on clk_i
// Behaviour
// - suspended port gets no repeated traffic, no resume unless it originated there
// - resume on suspended port drives K back, sets resume flag, raises hub interrupt
// - disconnect on a suspended port clears its selective suspend bit
// - remote wake bit gates upstream resume on downstream connect or disconnect
// - downstream remote wakeup propagates regardless; interrupt independent of that bit
// - suspend and resume status registers clear on chip reset and bus reset
// - resume status has four hardware flags, upper bits read zero
// - clearing suspend bit clears resume flag and stops hardware K; forcing continues
// - suspended hub on resume drives K upstream, to enabled unsuspended ports, interrupts
// - leaving suspend, hold firmware off at least 1 ms by counter
// - every allowed downstream change wakes the part even without remote wake
// - three-bit upstream code forces pins; zero leaves the SIE driving
// - bus activity flag set by SIE, sticky, written zero clears, one keeps
// - two read-only bits show live upstream D- and D+ levels
// - bit 7 endpoint size, bit 6 endpoint mode; register clears on reset
// - hub generates end-of-packet toward ports at EOF1 each frame
// - each port has two-bit forcing: normal, diff one, diff zero, SE0
// - babble clears a port enable; all enables clear on reset or bus reset
`include "hub_port_consts.vh"
module hub_port_ctl #(
  parameter NPORT     = 4,
  parameter WAKE_HOLD = `WAKE_HOLD_CYC
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             sys_rst_i,
  input  wire             bus_reset_i,
  // axi4-lite slave
  input  wire [11:0]      s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [11:0]      s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // downstream port events from the repeater (same clock)
  input  wire [NPORT-1:0] ds_resume_det_i,
  input  wire [NPORT-1:0] ds_disconnect_i,
  input  wire [NPORT-1:0] ds_connect_i,
  input  wire [NPORT-1:0] ds_babble_i,
  input  wire [NPORT-1:0] ds_traffic_i,
  input  wire [2*NPORT-1:0] ds_force_i,
  input  wire             eof1_i,
  // downstream port controls
  output reg  [NPORT-1:0] ds_fwd_en_o,
  output reg  [NPORT-1:0] ds_hw_k_o,
  output reg  [NPORT-1:0] ds_eop_o,
  output reg  [2*NPORT-1:0] ds_drive_o,
  // hub suspend / wake
  input  wire             hub_suspended_i,
  input  wire             up_resume_det_i,
  output reg              up_k_o,
  output reg              wake_o,
  output reg              fw_hold_o,
  output reg              hub_irq_o,
  input  wire             hub_irq_ack_i,
  // upstream port
  input  wire             sie_activity_i,
  input  wire             sie_dp_i,
  input  wire             sie_dm_i,
  input  wire             sie_oe_i,
  input  wire             up_dp_pin_i,
  input  wire             up_dm_pin_i,
  output reg              up_dp_o,
  output reg              up_dm_o,
  output reg              up_dp_oe_n_o,
  output reg              up_dm_oe_n_o,
  output wire             ep_size_o,
  output wire             ep_mode_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0]       ups_ctl;
  reg [7:0]       sel_susp;
  reg [NPORT-1:0] resume_stat;
  reg [NPORT-1:0] port_en;
  reg [11:0]      aw_addr;
  reg             aw_full;
  reg [31:0]      w_data;
  reg [3:0]       w_strb;
  reg             w_full;
  reg [31:0]      wake_cnt;
  reg             waking;
  wire [1:0]      up_lvl;
  wire            clr_all = sys_rst_i | bus_reset_i;
  wire            wr_go   = aw_full & w_full & ~s_axi_bvalid;
  wire            wr_ups  = wr_go & w_strb[0] & (aw_addr == `UPS_CTL_ADDR);
  wire            wr_susp = wr_go & w_strb[0] & (aw_addr == `SEL_SUSP_ADDR);
  wire            wr_en   = wr_go & w_strb[0] & (aw_addr == `PORT_ENABLE_ADDR);
  wire [NPORT-1:0] susp   = sel_susp[NPORT-1:0];
  integer         p;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `UPS_CTL_ADDR) || (a == `SEL_SUSP_ADDR) ||
               (a == `RESUME_STAT_ADDR) || (a == `PORT_ENABLE_ADDR);
    end
  endfunction

  assign s_axi_awready = ~aw_full;
  assign s_axi_wready  = ~w_full;
  assign s_axi_arready = ~s_axi_rvalid;
  assign ep_size_o     = ups_ctl[`EP_SIZE_BIT];
  assign ep_mode_o     = ups_ctl[`EP_MODE_BIT];

  pin_sync3 #(.W(2)) u_up_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({up_dp_pin_i, up_dm_pin_i}),
    .sync_o    (up_lvl)
  );

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_addr <= s_axi_awaddr;
        aw_full <= 1'b1;
      end
      if (s_axi_wvalid && !w_full) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_full <= 1'b1;
      end
      if (wr_go) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h00000000;
      if (s_axi_araddr == `UPS_CTL_ADDR) begin
        s_axi_rdata[7:0] <= {ups_ctl[7:6], up_lvl[1], up_lvl[0], ups_ctl[3:0]};
      end else if (s_axi_araddr == `SEL_SUSP_ADDR) begin
        s_axi_rdata[7:0] <= sel_susp;
      end else if (s_axi_araddr == `RESUME_STAT_ADDR) begin
        s_axi_rdata[NPORT-1:0] <= resume_stat;
      end else if (s_axi_araddr == `PORT_ENABLE_ADDR) begin
        s_axi_rdata[NPORT-1:0] <= port_en;
      end else begin
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // upstream status and control
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ups_ctl <= `REG_RESET;
    end else begin
      if (wr_ups) begin
        ups_ctl[7:6] <= w_data[7:6];
        ups_ctl[2:0] <= w_data[2:0];
      end
      // set wins over a clearing write in the same cycle
      if (sie_activity_i) begin
        ups_ctl[`BUS_ACT_BIT] <= 1'b1;
      end else if (wr_ups && !w_data[`BUS_ACT_BIT]) begin
        ups_ctl[`BUS_ACT_BIT] <= 1'b0;
      end
    end
  end

  // upstream pin drive; oe low means driving, K from resume overrides only SIE mode
  always @* begin
    up_dp_o      = sie_dp_i;
    up_dm_o      = sie_dm_i;
    up_dp_oe_n_o = ~sie_oe_i;
    up_dm_oe_n_o = ~sie_oe_i;
    case (ups_ctl[2:0])
      `UPS_SIE: begin
        if (up_k_o) begin
          up_dp_o      = 1'b0;
          up_dm_o      = 1'b1;
          up_dp_oe_n_o = 1'b0;
          up_dm_oe_n_o = 1'b0;
        end
      end
      `UPS_J: begin
        up_dp_o = 1'b1; up_dm_o = 1'b0; up_dp_oe_n_o = 1'b0; up_dm_oe_n_o = 1'b0;
      end
      `UPS_K: begin
        up_dp_o = 1'b0; up_dm_o = 1'b1; up_dp_oe_n_o = 1'b0; up_dm_oe_n_o = 1'b0;
      end
      `UPS_SE0, `UPS_LOW: begin
        up_dp_o = 1'b0; up_dm_o = 1'b0; up_dp_oe_n_o = 1'b0; up_dm_oe_n_o = 1'b0;
      end
      `UPS_DP_FLOAT: begin
        up_dp_o = 1'b0; up_dm_o = 1'b0; up_dp_oe_n_o = 1'b1; up_dm_oe_n_o = 1'b0;
      end
      `UPS_DM_FLOAT: begin
        up_dp_o = 1'b0; up_dm_o = 1'b0; up_dp_oe_n_o = 1'b0; up_dm_oe_n_o = 1'b1;
      end
      default: begin
        up_dp_o = 1'b0; up_dm_o = 1'b0; up_dp_oe_n_o = 1'b1; up_dm_oe_n_o = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // selective suspend, resume status and port enables
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (clr_all) begin
      sel_susp    <= `REG_RESET;
      resume_stat <= {NPORT{1'b0}};
      port_en     <= {NPORT{1'b0}};
    end else begin
      if (wr_susp) begin
        sel_susp <= w_data[7:0];
      end
      if (wr_en) begin
        port_en <= w_data[NPORT-1:0];
      end
      for (p = 0; p < NPORT; p = p + 1) begin
        if (ds_babble_i[p]) begin
          port_en[p] <= 1'b0;
        end
        if (susp[p] && ds_disconnect_i[p]) begin
          sel_susp[p]    <= 1'b0;
          resume_stat[p] <= 1'b0;
        end else if (wr_susp && !w_data[p]) begin
          resume_stat[p] <= 1'b0;
        end else if (susp[p] && ds_resume_det_i[p]) begin
          resume_stat[p] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // downstream drive, forwarding and end-of-packet
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (clr_all) begin
      ds_fwd_en_o <= {NPORT{1'b0}};
      ds_hw_k_o   <= {NPORT{1'b0}};
      ds_eop_o    <= {NPORT{1'b0}};
      ds_drive_o  <= {2*NPORT{1'b0}};
    end else begin
      ds_fwd_en_o <= port_en & ~susp;
      ds_eop_o    <= eof1_i ? (port_en & ~susp) : {NPORT{1'b0}};
      // firmware forcing passes through whatever the hardware K does
      ds_drive_o  <= ds_force_i;
      for (p = 0; p < NPORT; p = p + 1) begin
        // resume from the port itself or a global resume on an enabled, unsuspended port
        ds_hw_k_o[p] <= (resume_stat[p] & susp[p]) | (up_k_o & port_en[p] & ~susp[p]);
      end
    end
  end

  // ----------------------------------------------------------------
  // wake, upstream resume and hub interrupt
  // ----------------------------------------------------------------
  wire ds_change  = |(ds_connect_i | ds_disconnect_i);
  wire ds_wake    = |ds_resume_det_i;
  wire rwake_ev   = |(ds_resume_det_i & susp);
  wire up_prop    = ds_wake | (ds_change & sel_susp[`REMOTE_WAKE_BIT]);
  wire irq_event  = rwake_ev | (hub_suspended_i & (up_resume_det_i | ds_wake));

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      up_k_o    <= 1'b0;
      wake_o    <= 1'b0;
      hub_irq_o <= 1'b0;
      fw_hold_o <= 1'b0;
      waking    <= 1'b0;
      wake_cnt  <= 32'h00000000;
    end else begin
      up_k_o <= hub_suspended_i & (up_resume_det_i | up_prop);
      wake_o <= hub_suspended_i & (up_resume_det_i | ds_wake | ds_change);
      if (irq_event) begin
        hub_irq_o <= 1'b1;
      end else if (hub_irq_ack_i) begin
        hub_irq_o <= 1'b0;
      end
      // hold firmware until the restarted clock has settled for the full count
      if (hub_suspended_i) begin
        waking    <= 1'b1;
        fw_hold_o <= 1'b1;
        wake_cnt  <= 32'h00000000;
      end else if (waking) begin
        if (wake_cnt >= WAKE_HOLD - 1) begin
          waking    <= 1'b0;
          fw_hold_o <= 1'b0;
        end else begin
          wake_cnt <= wake_cnt + 32'h00000001;
        end
      end
    end
  end
endmodule // hub_port_ctl

// ==== include/hub_port_consts.vh ====
// constants for the hub port suspend/resume and upstream control block
// assumes an AXI4-Lite slave with 32-bit data, one register per aligned word
`ifndef HUB_PORT_CONSTS_VH
`define HUB_PORT_CONSTS_VH

// ----------------------------------------------------------------
// register byte addresses (printed offsets are indices, address = 4 * index)
// ----------------------------------------------------------------
`define UPS_CTL_IDX        8'h1F
`define SEL_SUSP_IDX       8'h4D
`define RESUME_STAT_IDX    8'h4E
`define PORT_ENABLE_IDX    8'h60
`define UPS_CTL_ADDR       12'h07C
`define SEL_SUSP_ADDR      12'h134
`define RESUME_STAT_ADDR   12'h138
`define PORT_ENABLE_ADDR   12'h180

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define REMOTE_WAKE_BIT    7
`define BUS_ACT_BIT        3
`define DM_LEVEL_BIT       4
`define DP_LEVEL_BIT       5
`define EP_MODE_BIT        6
`define EP_SIZE_BIT        7
`define REG_RESET          8'h00

// ----------------------------------------------------------------
// upstream forcing codes
// ----------------------------------------------------------------
`define UPS_SIE            3'h0
`define UPS_J              3'h1
`define UPS_K              3'h2
`define UPS_SE0            3'h3
`define UPS_LOW            3'h4
`define UPS_DP_FLOAT       3'h5
`define UPS_DM_FLOAT       3'h6
`define UPS_FLOAT          3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ            200
`define WAKE_HOLD_US       1000
`define WAKE_HOLD_CYC      (`WAKE_HOLD_US * `CLK_MHZ)

`endif

// ==== design/pin_sync3.v ====
// three-stage synchroniser for a bus of pin inputs
// assumes the inputs are asynchronous to clk_i; change counts when stages 2 and 3 agree
module pin_sync3 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         sys_rst_i,
  // pins and result
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer     i;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1     <= {W{1'b0}};
      s2     <= {W{1'b0}};
      s3     <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      // a bit moves only once the last two stages agree, filtering a lone glitch
      for (i = 0; i < W; i = i + 1) begin
        if (s2[i] == s3[i]) begin
          sync_o[i] <= s3[i];
        end
      end
    end
  end
endmodule // pin_sync3

// ==== verification/hub_port_ctl_assertions.sv ====
// checker for the hub port control block, watching its ports only
// assumes sys_rst_i is a synchronous active-high reset on clk_i
module hub_port_ctl_checker #(
  parameter NPORT = 4
) (
  input wire logic               clk_i, sys_rst_i, bus_reset_i, eof1_i,
  input wire logic               hub_suspended_i, up_resume_det_i, hub_irq_ack_i,
  input wire logic [NPORT-1:0]   ds_connect_i, ds_fwd_en_o, ds_hw_k_o, ds_eop_o,
  input wire logic [2*NPORT-1:0] ds_force_i, ds_drive_o,
  input wire logic               up_k_o, wake_o, fw_hold_o, hub_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_wake_answer;
    ##[1:3] (up_k_o && hub_irq_o);
  endsequence
  sequence s_hold_run;
    fw_hold_o [*8];
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_hwk_no_fwd;
    (ds_hw_k_o & ds_fwd_en_o) != '0 |-> $past(up_k_o);
  endproperty
  property p_irq_hold;
    hub_irq_o && !hub_irq_ack_i && !bus_reset_i |=> hub_irq_o;
  endproperty
  property p_bus_reset_clr;
    bus_reset_i |-> ##2 (ds_fwd_en_o == '0 && ds_hw_k_o == '0);
  endproperty
  property p_force_pass;
    $changed(ds_force_i) && !bus_reset_i |=> ds_drive_o == $past(ds_force_i);
  endproperty
  property p_eop_follow;
    eof1_i && !bus_reset_i |=> ds_eop_o == ds_fwd_en_o;
  endproperty
  property p_eop_quiet;
    !eof1_i |=> ds_eop_o == '0;
  endproperty
  property p_hold_susp;
    hub_suspended_i |=> fw_hold_o;
  endproperty
  property p_hold_min;
    $fell(hub_suspended_i) |-> s_hold_run;
  endproperty
  property p_up_wake;
    hub_suspended_i && up_resume_det_i |-> s_wake_answer;
  endproperty
  property p_wake_any;
    hub_suspended_i && (|ds_connect_i) |-> ##[1:3] wake_o;
  endproperty
  a_hwk_no_fwd: assert property (p_hwk_no_fwd)
    else $error("hardware k on a forwarding port");
  a_irq_hold: assert property (p_irq_hold)
    else $error("hub interrupt dropped without ack");
  a_bus_reset_clr: assert property (p_bus_reset_clr)
    else $error("bus reset left a port live");
  a_force_pass: assert property (p_force_pass)
    else $error("port forcing code not passed on");
  a_eop_follow: assert property (p_eop_follow)
    else $error("end of packet not on forwarding ports");
  a_eop_quiet: assert property (p_eop_quiet)
    else $error("end of packet without checkpoint");
  a_hold_susp: assert property (p_hold_susp)
    else $error("firmware not held while suspended");
  a_hold_min: assert property (p_hold_min)
    else $error("firmware hold too short");
  a_up_wake: assert property (p_up_wake)
    else $error("suspended resume gave no k or interrupt");
  a_wake_any: assert property (p_wake_any)
    else $error("port change did not wake the part");
endmodule // hub_port_ctl_checker

// ==== verification/hub_far_side.sv ====
// far side model: downstream devices and the upstream host
// assumes one event at a time, requested by the bench on clk_i
module hub_far_side (
  input  wire logic       clk_i, go_i, host_k_i, dp_i, dm_i, dp_oe_n_i, dm_oe_n_i,
  input  wire logic [1:0] kind_i, port_i,
  output logic [15:0]     ev_o,
  output wire logic       dp_pin_o, dm_pin_o
);
  // one-cycle pulse: resume, disconnect, connect, babble, four ports each
  always @(posedge clk_i) begin
    ev_o <= go_i ? (16'h0001 << {kind_i, port_i}) : 16'h0000;
  end
  // a released host leaves the device pull-up on d+ and its pull-down on d-
  assign dp_pin_o = !dp_oe_n_i ? dp_i : !host_k_i;
  assign dm_pin_o = !dm_oe_n_i ? dm_i : host_k_i;
endmodule // hub_far_side

// ==== verification/testbench.sv ====
// self-checking bench for the hub port control block
// assumes the checker and far side model are compiled before it
`include "hub_port_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = '0, sys_rst_i = '1, bus_reset_i = '0, eof1_i = '0, hub_suspended_i = '0, go = '0, host_k = '0;
  logic up_resume_det_i = '0, hub_irq_ack_i = '0, sie_activity_i = '0, sie_dp_i = '0, sie_dm_i = '1, sie_oe_i = '1;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF, ds_traffic_i = 4'h0, ds_resume_det_i, ds_disconnect_i, ds_connect_i, ds_babble_i;
  logic [3:0]  ds_fwd_en_o, ds_hw_k_o, ds_eop_o;
  logic [7:0]  ds_force_i = '0, ds_drive_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, kind = '0, port = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, up_k_o, wake_o, fw_hold_o, hub_irq_o;
  logic up_dp_pin_i, up_dm_pin_i, up_dp_o, up_dm_o, up_dp_oe_n_o, up_dm_oe_n_o, ep_size_o, ep_mode_o;
  logic [15:0] ev;
  logic [3:0]  pins [8] = '{4'h4, 4'h8, 4'h4, 4'h0, 4'h0, 4'hA, 4'h5, 4'hF};
  int num_errors = 0, checks = 0;
  assign {ds_babble_i, ds_connect_i, ds_disconnect_i, ds_resume_det_i} = ev;
  hub_port_ctl #(.WAKE_HOLD(20)) u_hub_port_ctl (.*);
  hub_far_side u_hub_far_side (.clk_i(clk_i), .go_i(go), .host_k_i(host_k), .dp_i(up_dp_o), .dm_i(up_dm_o),
    .dp_oe_n_i(up_dp_oe_n_o), .dm_oe_n_i(up_dm_oe_n_o), .kind_i(kind), .port_i(port), .ev_o(ev),
    .dp_pin_o(up_dp_pin_i), .dm_pin_o(up_dm_pin_i));
  always #2.5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic to(input string what, input logic ok);
    if (ok !== 1'b1) begin
      chk(what, 1, 0);
      tally_and_finish();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // write address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= '0;
    to("bvalid", s_axi_bvalid);
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= '0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= '0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    to("rvalid", s_axi_rvalid);
    chk(what, exp, rd);
  endtask
  task automatic fire(input logic [1:0] k, p);
    @(posedge clk_i);
    kind <= k;
    port <= p;
    go <= '1;
    @(posedge clk_i);
    go <= '0;
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? wake_o : s == 1 ? up_k_o : s == 2 ? hub_irq_o : fw_hold_o;
  endfunction
  task automatic wait_for(input int s, input logic v);
    int n;
    for (n = 0; n < 60 && pick(s) !== v; n++) @(posedge clk_i);
    to("wait", pick(s) === v);
  endtask
  task automatic pulse_ack;
    hub_irq_ack_i <= '1;
    tick(1);
    hub_irq_ack_i <= '0;
  endtask
  task automatic wake_end;
    hub_suspended_i <= '0;
    tick(15);
    chk("hold", 1, fw_hold_o);
    wait_for(3, 0);
    pulse_ack();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset;
    chk_rd(`UPS_CTL_ADDR, 32'h00000010, "ctl");
    chk_rd(`SEL_SUSP_ADDR, 0, "suspend");
    chk_rd(`RESUME_STAT_ADDR, 0, "resume");
    chk_rd(12'h004, 0, "unmapped");
    chk("unmapped resp", 2, rr);
  endtask
  task automatic s_upstream;
    int i;
    sie_activity_i <= '1;
    tick(1);
    sie_activity_i <= '0;
    chk_rd(`UPS_CTL_ADDR, 32'h00000018, "act set");
    wr(`UPS_CTL_ADDR, 8'h08);
    chk_rd(`UPS_CTL_ADDR, 32'h00000018, "act kept");
    wr(`UPS_CTL_ADDR, 8'h00);
    chk_rd(`UPS_CTL_ADDR, 32'h00000010, "act clr");
    sie_oe_i <= '0;
    tick(4);
    chk_rd(`UPS_CTL_ADDR, 32'h00000020, "pins j");
    host_k <= '1;
    tick(4);
    chk_rd(`UPS_CTL_ADDR, 32'h00000010, "pins k");
    host_k <= '0;
    sie_oe_i <= '1;
    for (i = 0; i < 8; i++) begin
      wr(`UPS_CTL_ADDR, 8'hC0 | i[7:0]);
      chk("pins", pins[i], {up_dp_oe_n_o | up_dp_o, up_dm_oe_n_o | up_dm_o, up_dp_oe_n_o, up_dm_oe_n_o});
    end
    chk("ep", 2'b11, {ep_size_o, ep_mode_o});
    wr(`UPS_CTL_ADDR, 8'h40);
    chk("ep", 2'b01, {ep_size_o, ep_mode_o});
    wr(`UPS_CTL_ADDR, 8'h00);
  endtask
  task automatic s_selective;
    wr(`PORT_ENABLE_ADDR, 8'h0F);
    wr(`SEL_SUSP_ADDR, 8'h01);
    eof1_i <= '1;
    tick(1);
    eof1_i <= '0;
    tick(1);
    chk("eop", 4'hE, ds_eop_o);
    chk("fwd", 4'hE, ds_fwd_en_o);
    fire(0, 0);
    wait_for(2, 1);
    tick(1);
    chk("hw k", 4'h1, ds_hw_k_o);
    chk_rd(`RESUME_STAT_ADDR, 1, "resume");
    pulse_ack();
    wait_for(2, 0);
    ds_force_i <= 8'h1E;
    wr(`PORT_ENABLE_ADDR, 8'h0E);
    wr(`SEL_SUSP_ADDR, 8'h00);
    tick(2);
    chk("hw k off", 0, ds_hw_k_o);
    chk("drive", 8'h1E, ds_drive_o);
    chk_rd(`RESUME_STAT_ADDR, 0, "resume off");
    ds_force_i <= 8'h00;
  endtask
  task automatic s_ports;
    wr(`SEL_SUSP_ADDR, 8'h02);
    fire(1, 1);
    chk_rd(`SEL_SUSP_ADDR, 0, "disconnect");
    fire(3, 2);
    chk_rd(`PORT_ENABLE_ADDR, 8'h0A, "babble");
    wr(`SEL_SUSP_ADDR, 8'h85);
    bus_reset_i <= '1;
    tick(1);
    bus_reset_i <= '0;
    chk_rd(`SEL_SUSP_ADDR, 0, "bus reset");
    chk_rd(`PORT_ENABLE_ADDR, 0, "bus reset en");
  endtask
  task automatic s_wake;
    hub_suspended_i <= '1;
    fire(2, 0);
    wait_for(0, 1);
    tick(6);
    chk("no up k", 0, up_k_o);
    wake_end();
    wr(`SEL_SUSP_ADDR, 8'h80);
    hub_suspended_i <= '1;
    fire(2, 1);
    wait_for(1, 1);
    wake_end();
    wr(`SEL_SUSP_ADDR, 8'h00);
    hub_suspended_i <= '1;
    fire(0, 2);
    wait_for(1, 1);
    wake_end();
    hub_suspended_i <= '1;
    up_resume_det_i <= '1;
    tick(1);
    up_resume_det_i <= '0;
    wait_for(1, 1);
    wait_for(2, 1);
    wake_end();
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(16);
    sys_rst_i <= '0;
    // the pin synchroniser needs a few edges before the level readback is live
    tick(4);
    s_reset();
    s_upstream();
    s_selective();
    s_ports();
    s_wake();
    tally_and_finish();
  end
endmodule // testbench
bind hub_port_ctl hub_port_ctl_checker #(.NPORT(NPORT)) u_hub_port_ctl_checker (.*);
